// *** sim/sep_master_model.sv ***
// Serial master model driving select, serial clock and data in.
`timescale 1ns/1ps
module sep_master_model (
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_sel,
  output logic o_sclk,
  output logic o_din
);
  // ==========================================================================
  // Pin levels at time zero.
  // ==========================================================================
  // The serial clock stands low outside frames.
  initial begin
    o_sel = 1'b0;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end

  // ==========================================================================
  // Link tasks, 125 ns clock unrelated in phase to the system clock.
  // ==========================================================================
  // Hold select low long enough to reset the framing.
  task automatic sel_lo;
    o_sel <= 1'b0;
    #300;
  endtask

  // Let the synchronisers see select before the first edge.
  task automatic sel_hi;
    o_sel <= 1'b1;
    #60;
  endtask

  // One clock; data out is read as the clock falls, well after it settles.
  task automatic pulse(input logic b, input realtime ph, input realtime pl, output logic r);
    o_din <= b;
    #(62.5 + pl) o_sclk <= 1'b1;
    #(62.5 + ph) o_sclk <= 1'b0;
    r = i_sdo_oe ? i_sdo : 1'bz;
  endtask

  // Sends the low n bits of v most significant first, after lead idle clocks.
  // The clock pauses once mid-frame, high or low as lead selects.
  task automatic xfer(input logic [24:0] v, input int n, input logic [1:0] lead, output logic [24:0] sh);
    logic r;
    sh = '0;
    for (int i = 0; i < lead; i++) pulse(1'b0, 0, 0, r);
    for (int i = n - 1; i >= 0; i--) begin
      pulse(v[i], (i == n / 2 && lead[0]) ? 400 : 0, (i == n / 2 && !lead[0]) ? 400 : 0, r);
      sh = {sh[23:0], r};
    end
  endtask
endmodule

// *** sim/sep_serial_eeprom_tb.sv ***
// Self-checking bench for the serial EEPROM command port.
`timescale 1ns/1ps
module sep_serial_eeprom_tb;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic sel, sclk, din, o_sdo, o_sdo_oe;
  logic [31:0] rnd = 32'h0000_406f;
  logic [15:0] mem [64];
  logic [24:0] sh;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  // Short programming cycles keep the run brief.
  sep_serial_eeprom #(.P_WC_CYC(200), .P_EC_CYC(400), .P_WL_CYC(600)) sep_serial_eeprom_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sel(sel), .i_sclk(sclk),
    .i_serial_data_in(din), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe));
  sep_master_model sep_master_model_inst (
    .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe), .o_sel(sel), .o_sclk(sclk), .o_din(din));

  // ==========================================================================
  // Clock and hang guard.
  // ==========================================================================
  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // The whole run needs about 13000 cycles.
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  function automatic logic [24:0] f9(input logic [1:0] op, input logic [5:0] a);
    return {16'h0000, 1'b1, op, a};
  endfunction

  function automatic logic [24:0] f25(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
    return {1'b1, op, a, d};
  endfunction

  // Random source for data, addresses and idle clocks; a fixed start keeps runs repeatable.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rn;
    rnd = lfsr_next(rnd);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask

  // A fresh select window, then n bits of an instruction.
  task automatic cmd(input logic [24:0] v, input int n);
    rn();
    sep_master_model_inst.sel_lo();
    sep_master_model_inst.sel_hi();
    sep_master_model_inst.xfer(v, n, rnd[1:0], sh);
  endtask

  task automatic rd(input logic [5:0] a);
    cmd(f25(sep_pkg::OPC_READ, a, 16'h0000), 25);
    chk({15'h0000, sh[16]}, 16'h0000);
    chk(sh[15:0], mem[a]);
  endtask

  // Reselect and poll the ready/busy status without any serial clock.
  // Outputs are read on the falling edge, where they have settled.
  task automatic stat;
    sep_master_model_inst.sel_lo();
    sep_master_model_inst.sel_hi();
    repeat (3) @(negedge i_clk_sys);
    chk({14'h0000, o_sdo_oe, o_sdo}, 16'h0002);
    for (int i = 0; i < 1000 && o_sdo !== 1'b1; i++) @(negedge i_clk_sys);
    chk({14'h0000, o_sdo_oe, o_sdo}, 16'h0003);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    logic [5:0] a;
    logic [15:0] d;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    chk({15'h0000, o_sdo_oe}, 16'h0000);
    cmd(f25(sep_pkg::OPC_EXT, 6'h10, 16'h1234), 25);
    sep_master_model_inst.sel_lo();
    sep_master_model_inst.sel_hi();
    chk({15'h0000, o_sdo_oe}, 16'h0000);
    $display("test disabled write done");
    cmd(f9(sep_pkg::OPC_EXT, 6'h30), 9);
    // The data is kept aside, since every instruction draws a fresh random value.
    rn();
    d = rnd[15:0];
    cmd(f25(sep_pkg::OPC_EXT, 6'h10, d), 25);
    foreach (mem[i]) mem[i] = d;
    stat();
    for (int k = 0; k < 3; k++) begin
      rn();
      rd(rnd[5:0]);
    end
    $display("test write all done");
    for (int k = 0; k < 4; k++) begin
      rn();
      a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : rnd[21:16];
      mem[a] = rnd[15:0];
      cmd(f25(sep_pkg::OPC_WRITE, a, rnd[15:0]), 25);
      if (k < 3) begin
        stat();
      end else begin
        sep_master_model_inst.sel_lo();
        #3000;
        chk({15'h0000, o_sdo_oe}, 16'h0000);
        sep_master_model_inst.sel_hi();
        repeat (3) @(negedge i_clk_sys);
        chk({14'h0000, o_sdo_oe, o_sdo}, 16'h0003);
      end
      rd(a);
    end
    $display("test write done");
    cmd(f9(sep_pkg::OPC_ERASE, 6'h3f), 9);
    mem[63] = 16'hffff;
    // A short erase of word 0, clocked without idle lead, ends well inside the busy time.
    sep_master_model_inst.sel_lo();
    sep_master_model_inst.sel_hi();
    sep_master_model_inst.xfer(f9(sep_pkg::OPC_ERASE, 6'h00), 9, 2'h0, sh);
    #3000;
    rd(6'h3f);
    rd(6'h00);
    cmd(f25(sep_pkg::OPC_WRITE, 6'h05, ~mem[5]) >> 10, 15);
    #3000;
    rd(6'h05);
    rd(6'h3f);
    sep_master_model_inst.xfer(25'h000_0000, 16, 2'h0, sh);
    chk(sh[15:0], mem[0]);
    sep_master_model_inst.sel_lo();
    chk({15'h0000, o_sdo_oe}, 16'h0000);
    $display("test erase and read done");
    cmd(f9(sep_pkg::OPC_EXT, 6'h20), 9);
    foreach (mem[i]) mem[i] = 16'hffff;
    stat();
    cmd(f9(sep_pkg::OPC_EXT, 6'h30), 9);
    sep_master_model_inst.xfer(f25(sep_pkg::OPC_WRITE, 6'h09, 16'h0000), 25, 2'h0, sh);
    #3000;
    rd(6'h09);
    cmd(f9(sep_pkg::OPC_EXT, 6'h00), 9);
    cmd(f25(sep_pkg::OPC_WRITE, 6'h09, 16'h0000), 25);
    #3000;
    rd(6'h09);
    $display("test erase all and disable done");
    report_and_stop();
  end
endmodule

// *** src/sep_mem_if.sv ***
// Carrier between the command port and the programming engine.
`timescale 1ns/1ps
interface sep_mem_if;
  logic start;
  sep_pkg::sep_pop_t op;
  logic [sep_pkg::ADDR_W-1:0] addr;
  logic [sep_pkg::DATA_W-1:0] wdata;
  logic [sep_pkg::ADDR_W-1:0] rd_addr;
  logic [sep_pkg::DATA_W-1:0] rd_data;
  logic busy;

  modport ctrl (output start, op, addr, wdata, rd_addr, input rd_data, busy);
  modport mem (input start, op, addr, wdata, rd_addr, output rd_data, busy);
endinterface

// *** src/sep_pkg.sv ***
// Shared constants and types for the serial EEPROM command port.
package sep_pkg;

  // ==========================================================================
  // Array geometry.
  // ==========================================================================
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORDS = 64;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic PE_RESET = 1'b0;

  // ==========================================================================
  // Timing: system clock, select low time and self-timed cycle lengths.
  // ==========================================================================
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned TCSL_NS = 250;
  // A least time, so it rounds up to whole cycles.
  localparam logic [4:0] TCSL_CYC = 5'((TCSL_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned T_WC_MS = 2;
  localparam int unsigned T_EC_MS = 6;
  localparam int unsigned T_WL_MS = 15;
  // Longest times, so they round down.
  localparam int unsigned WC_CYC = T_WC_MS * NS_PER_MS / CLK_NS;
  localparam int unsigned EC_CYC = T_EC_MS * NS_PER_MS / CLK_NS;
  localparam int unsigned WL_CYC = T_WL_MS * NS_PER_MS / CLK_NS;

  // ==========================================================================
  // Instruction framing and codes.
  // ==========================================================================
  localparam logic [4:0] CMD_CLKS = 5'h09;
  localparam logic [4:0] XFER_CLKS = 5'h19;
  localparam logic [3:0] RD_LAST_BIT = 4'hF;
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] EXT_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE = 2'h3;

  typedef enum logic [1:0] {POP_ERASE, POP_ERASE_ALL, POP_WRITE, POP_WRITE_ALL} sep_pop_t;
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_WDATA, ST_READ, ST_DONE} sep_state_t;

endpackage

// *** src/sep_prog_engine.sv ***
// Word array and self-timed erase and programming engine.
`timescale 1ns/1ps
module sep_prog_engine #(
  parameter int unsigned P_WC_CYC = sep_pkg::WC_CYC,
  parameter int unsigned P_EC_CYC = sep_pkg::EC_CYC,
  parameter int unsigned P_WL_CYC = sep_pkg::WL_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  sep_mem_if.mem m
);

  // ==========================================================================
  // Storage and cycle state.
  // ==========================================================================
  logic [sep_pkg::DATA_W-1:0] mem_r [sep_pkg::WORDS];
  logic busy_r;
  logic [23:0] cnt_r;
  sep_pkg::sep_pop_t op_r;
  logic [sep_pkg::ADDR_W-1:0] addr_r;
  logic [sep_pkg::DATA_W-1:0] data_r;

  // Cycle length for each kind of programming operation.
  function automatic logic [23:0] cyc_len(input sep_pkg::sep_pop_t op);
    logic [23:0] len;
    len = 24'(P_WC_CYC);
    if (op == sep_pkg::POP_ERASE_ALL) begin
      len = 24'(P_EC_CYC);
    end else if (op == sep_pkg::POP_WRITE_ALL) begin
      len = 24'(P_WL_CYC);
    end
    return len;
  endfunction

  // The timer runs on the system clock alone, so no serial clock edge is needed.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      busy_r <= 1'b0;
      cnt_r <= 24'h00_0000;
      op_r <= sep_pkg::POP_ERASE;
      addr_r <= '0;
      data_r <= '0;
    end else if (m.start && !busy_r) begin
      busy_r <= 1'b1;
      cnt_r <= cyc_len(m.op);
      op_r <= m.op;
      addr_r <= m.addr;
      data_r <= m.wdata;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 24'h00_0001;
      if (cnt_r == 24'h00_0001) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Array updates land at the end of the cycle; write-all clears the array half way.
  // Contents are nonvolatile, so the array has no reset.
  always_ff @(posedge i_clk_sys) begin
    if (busy_r && cnt_r == 24'h00_0001) begin
      case (op_r)
        sep_pkg::POP_ERASE: mem_r[addr_r] <= sep_pkg::ERASED_WORD;
        sep_pkg::POP_WRITE: mem_r[addr_r] <= data_r;
        sep_pkg::POP_ERASE_ALL: begin
          for (int i = 0; i < sep_pkg::WORDS; i++) begin
            mem_r[i] <= sep_pkg::ERASED_WORD;
          end
        end
        default: begin
          for (int i = 0; i < sep_pkg::WORDS; i++) begin
            mem_r[i] <= data_r;
          end
        end
      endcase
    end else if (busy_r && op_r == sep_pkg::POP_WRITE_ALL && cnt_r == (cyc_len(op_r) >> 1)) begin
      for (int i = 0; i < sep_pkg::WORDS; i++) begin
        mem_r[i] <= sep_pkg::ERASED_WORD;
      end
    end
  end

  assign m.rd_data = mem_r[m.rd_addr];
  assign m.busy = busy_r;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_cycle_starts: assert property (m.start && !busy_r |=> busy_r && cnt_r == cyc_len(op_r))
    else $error("programming cycle did not start");
  a_erase_ones: assert property (busy_r && cnt_r == 24'h00_0001 && op_r == sep_pkg::POP_ERASE
    |=> !busy_r && mem_r[addr_r] == sep_pkg::ERASED_WORD)
    else $error("erased word is not all ones");

endmodule

// *** src/sep_serial_eeprom.sv ***
// Command port of a 64 by 16 serial EEPROM behind a three-wire serial link.
// Function
// - Deselect enters standby only after any running programming cycle ends.
// - Select low resets command logic; master keeps select low 250 ns between instructions.
// - Inputs sampled and output bits updated on rising serial clock edges.
// - Serial clock may pause at either level anywhere in a transfer.
// - Before a start bit, any number of clocks changes nothing.
// - Start bit is first rising clock edge with select and data in high.
// - Execute only after 9 clocks (short commands, read) or 25 clocks (write, write-all).
// - After the last bit, clock and data in are ignored until a new start.
// - Data out floats except for read data or status; floats on deselect.
// - Reselect after minimum low time shows busy low, ready high.
// - Select low for whole cycle keeps output floating; later check shows high.
// - Leave standby as soon as select rises.
// - Start program-disabled; erase and write rejected until enabled; read always works.
// - Erase sets the addressed word to all ones from the last address edge.
// - Erase-all sets the whole array to ones, self-timed from the last address edge.
// - Programming cycles complete with no serial clock edges.
// - Read outputs a zero dummy bit, then the 16-bit word.
// - While select stays high, read continues with following words.
// - Write stores sixteen data bits, cycle starting after the last data bit.
// - Write-all erases the array, then programs every word; needs enable.
`timescale 1ns/1ps
module sep_serial_eeprom #(
  parameter int unsigned P_WC_CYC = sep_pkg::WC_CYC,
  parameter int unsigned P_EC_CYC = sep_pkg::EC_CYC,
  parameter int unsigned P_WL_CYC = sep_pkg::WL_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_sel,
  input wire logic i_sclk,
  input wire logic i_serial_data_in,
  output logic o_sdo,
  output logic o_sdo_oe
);

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  sep_mem_if mif ();
  logic sel_s1, sel_s2, sel_d_r;
  logic sclk_s1, sclk_s2, sclk_d_r;
  logic din_s1, din_s2;
  logic rise, sel_fall, sel_rise;
  logic [4:0] sel_low_cnt_r;
  sep_pkg::sep_state_t st_r;
  logic [4:0] bcnt_r;
  logic [7:0] cmd_sh_r;
  logic [15:0] wd_sh_r;
  logic [7:0] cmd_word;
  logic [15:0] data_word;
  logic start_ev, last_cmd, last_data, rd_go;
  logic [1:0] opc_r;
  logic [5:0] addr_r;
  logic pe_r;
  logic start_r;
  sep_pkg::sep_pop_t pop_r;
  logic [15:0] wdata_r;
  logic [15:0] rd_sh_r;
  logic [3:0] rd_cnt_r;
  logic stat_arm_r, stat_mode_r;
  logic o_sdo_r, o_sdo_oe_r;

  // ==========================================================================
  // Pin synchronisers and edge detection.
  // ==========================================================================
  // Every pin passes two flops; the serial clock is sampled, not used as a clock.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      sel_s1 <= i_sel;
      sel_s2 <= sel_s1;
      sclk_s1 <= i_sclk;
      sclk_s2 <= sclk_s1;
      din_s1 <= i_serial_data_in;
      din_s2 <= din_s1;
    end
  end

  // Delayed copies for edge finding.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sel_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else begin
      sel_d_r <= sel_s2;
      sclk_d_r <= sclk_s2;
    end
  end

  // Edge-based sampling means a paused clock, high or low, simply waits.
  assign rise = sclk_s2 & ~sclk_d_r;
  assign sel_fall = ~sel_s2 & sel_d_r;
  assign sel_rise = sel_s2 & ~sel_d_r;

  // Select low time, saturating; it still holds the low count in the rising cycle.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || sel_s2) begin
      sel_low_cnt_r <= 5'h00;
    end else if (sel_low_cnt_r != sep_pkg::TCSL_CYC) begin
      sel_low_cnt_r <= sel_low_cnt_r + 5'h01;
    end
  end

  // ==========================================================================
  // Command framing.
  // ==========================================================================
  // A start is refused while a cycle runs, so it is recognised only afterwards.
  assign start_ev = rise && sel_s2 && st_r == sep_pkg::ST_IDLE && din_s2 && !mif.busy;
  assign cmd_word = {cmd_sh_r[6:0], din_s2};
  assign data_word = {wd_sh_r[14:0], din_s2};
  assign last_cmd = rise && st_r == sep_pkg::ST_CMD && bcnt_r == sep_pkg::CMD_CLKS - 5'h01;
  assign last_data = rise && st_r == sep_pkg::ST_WDATA && bcnt_r == sep_pkg::XFER_CLKS - 5'h01;
  assign rd_go = last_cmd && cmd_word[7:6] == sep_pkg::OPC_READ;

  // Deselect holds the framing in its idle state; programming is unaffected.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !sel_s2) begin
      st_r <= sep_pkg::ST_IDLE;
      bcnt_r <= 5'h00;
    end else if (rise) begin
      case (st_r)
        sep_pkg::ST_IDLE: begin
          if (start_ev) begin
            st_r <= sep_pkg::ST_CMD;
            bcnt_r <= 5'h01;
          end
        end
        sep_pkg::ST_CMD: begin
          bcnt_r <= bcnt_r + 5'h01;
          if (last_cmd) begin
            if (cmd_word[7:6] == sep_pkg::OPC_READ) begin
              st_r <= sep_pkg::ST_READ;
            end else if (cmd_word[7:6] == sep_pkg::OPC_WRITE ||
                         cmd_word[7:4] == {sep_pkg::OPC_EXT, sep_pkg::EXT_WRITE_ALL}) begin
              st_r <= sep_pkg::ST_WDATA;
            end else begin
              st_r <= sep_pkg::ST_DONE;
            end
          end
        end
        sep_pkg::ST_WDATA: begin
          bcnt_r <= bcnt_r + 5'h01;
          if (last_data) begin
            st_r <= sep_pkg::ST_DONE;
          end
        end
        default: begin
          st_r <= st_r;
        end
      endcase
    end
  end

  // Opcode, address and data shift in most significant bit first.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cmd_sh_r <= 8'h00;
      wd_sh_r <= 16'h0000;
      opc_r <= sep_pkg::OPC_EXT;
    end else if (rise && st_r == sep_pkg::ST_CMD) begin
      cmd_sh_r <= cmd_word;
      if (last_cmd) begin
        opc_r <= cmd_word[7:6];
      end
    end else if (rise && st_r == sep_pkg::ST_WDATA) begin
      wd_sh_r <= data_word;
    end
  end

  // ==========================================================================
  // Program enable and programming requests.
  // ==========================================================================
  // A reset, standing for power loss, or the disable instruction returns the device to disabled.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pe_r <= sep_pkg::PE_RESET;
    end else if (last_cmd && cmd_word[7:4] == {sep_pkg::OPC_EXT, sep_pkg::EXT_ENABLE}) begin
      pe_r <= 1'b1;
    end else if (last_cmd && cmd_word[7:4] == {sep_pkg::OPC_EXT, sep_pkg::EXT_DISABLE}) begin
      pe_r <= 1'b0;
    end
  end

  // Erase kinds start at the last address edge, write kinds at the last data edge.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      start_r <= 1'b0;
      pop_r <= sep_pkg::POP_ERASE;
      wdata_r <= 16'h0000;
    end else begin
      start_r <= 1'b0;
      if (pe_r && last_cmd && cmd_word[7:6] == sep_pkg::OPC_ERASE) begin
        start_r <= 1'b1;
        pop_r <= sep_pkg::POP_ERASE;
      end else if (pe_r && last_cmd && cmd_word[7:4] == {sep_pkg::OPC_EXT, sep_pkg::EXT_ERASE_ALL}) begin
        start_r <= 1'b1;
        pop_r <= sep_pkg::POP_ERASE_ALL;
      end else if (pe_r && last_data) begin
        start_r <= 1'b1;
        pop_r <= (opc_r == sep_pkg::OPC_WRITE) ? sep_pkg::POP_WRITE : sep_pkg::POP_WRITE_ALL;
        wdata_r <= data_word;
      end
    end
  end

  assign mif.start = start_r;
  assign mif.op = pop_r;
  assign mif.addr = addr_r;
  assign mif.wdata = wdata_r;
  assign mif.rd_addr = addr_r;

  sep_prog_engine #(
    .P_WC_CYC(P_WC_CYC),
    .P_EC_CYC(P_EC_CYC),
    .P_WL_CYC(P_WL_CYC)
  ) u_prog (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .m(mif.mem)
  );

  // ==========================================================================
  // Read path.
  // ==========================================================================
  // The address register advances on each word fetch, wrapping at the top.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      addr_r <= 6'h00;
      rd_sh_r <= 16'h0000;
      rd_cnt_r <= 4'h0;
    end else if (last_cmd) begin
      addr_r <= cmd_word[5:0];
      rd_cnt_r <= 4'h0;
    end else if (rise && st_r == sep_pkg::ST_READ) begin
      if (rd_cnt_r == 4'h0) begin
        rd_sh_r <= {mif.rd_data[14:0], 1'b0};
        rd_cnt_r <= sep_pkg::RD_LAST_BIT;
        addr_r <= addr_r + 6'h01;
      end else begin
        rd_sh_r <= {rd_sh_r[14:0], 1'b0};
        rd_cnt_r <= rd_cnt_r - 4'h1;
      end
    end
  end

  // ==========================================================================
  // Status output.
  // ==========================================================================
  // Armed by any started cycle and kept after it ends, so a late check shows ready.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || start_ev) begin
      stat_arm_r <= 1'b0;
      stat_mode_r <= 1'b0;
    end else begin
      if (start_r) begin
        stat_arm_r <= 1'b1;
      end
      if (sel_fall) begin
        stat_mode_r <= 1'b0;
      end else if (sel_rise && (stat_arm_r || start_r) && sel_low_cnt_r == sep_pkg::TCSL_CYC) begin
        stat_mode_r <= 1'b1;
      end
    end
  end

  // Data out driver: dummy zero and read bits, else status, else floating.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !sel_s2) begin
      o_sdo_oe_r <= 1'b0;
      o_sdo_r <= 1'b0;
    end else if (rd_go) begin
      o_sdo_oe_r <= 1'b1;
      o_sdo_r <= 1'b0;
    end else if (rise && st_r == sep_pkg::ST_READ) begin
      o_sdo_r <= (rd_cnt_r == 4'h0) ? mif.rd_data[15] : rd_sh_r[15];
    end else if (st_r != sep_pkg::ST_READ) begin
      o_sdo_oe_r <= stat_mode_r;
      o_sdo_r <= stat_mode_r & ~mif.busy;
    end
  end

  assign o_sdo = o_sdo_r;
  assign o_sdo_oe = o_sdo_oe_r;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_read_decoded;
    rd_go;
  endsequence
  sequence s_dummy_out;
    o_sdo_oe_r && !o_sdo_r;
  endsequence

  a_dummy_zero: assert property (s_read_decoded |=> s_dummy_out)
    else $error("read did not begin with a driven zero");
  a_float_desel: assert property (sel_fall |=> !o_sdo_oe_r)
    else $error("data out still driven after deselect");
  a_ctrl_held: assert property (!sel_s2 |=> st_r == sep_pkg::ST_IDLE)
    else $error("control left idle while deselected");
  a_start_seen: assert property (start_ev |=> st_r == sep_pkg::ST_CMD && bcnt_r == 5'h01)
    else $error("start bit not taken");
  a_busy_block: assert property (st_r == sep_pkg::ST_IDLE && mif.busy |=> st_r == sep_pkg::ST_IDLE)
    else $error("instruction began during programming");
  a_enable_gate: assert property (start_r |-> $past(pe_r))
    else $error("programming started while disabled");
  a_exec_count: assert property (start_r |-> $past(st_r == sep_pkg::ST_WDATA && bcnt_r == 5'h18) ||
    $past(st_r == sep_pkg::ST_CMD && bcnt_r == 5'h08))
    else $error("instruction ran before full clock count");
  a_status_level: assert property (stat_mode_r && $past(stat_mode_r) && sel_s2 && st_r != sep_pkg::ST_READ
    |=> o_sdo_oe_r && o_sdo_r == !$past(mif.busy))
    else $error("status level does not follow busy");

endmodule
